// file: hw/tco_defs.vh
`ifndef TCO_DEFS_VH
`define TCO_DEFS_VH

// register indices on the 16-bit cpu port (word per index)
`define TCO_IDX_FUNC_CTRL   3'h0
`define TCO_IDX_LEVEL_CTRL  3'h1
`define TCO_IDX_CNT0        3'h2
`define TCO_IDX_CNT4        3'h6

// combination_function_control fields
`define TCO_FC_RESET        8'hC0
`define TCO_FC_FIXED_BIT    6
`define TCO_FC_MODE_HI      5
`define TCO_FC_MODE_LO      4
`define TCO_FC_BUF_HI       3
`define TCO_FC_BUF_LO       0

// combination mode encodings
`define TCO_MODE_NORMAL0    2'h0
`define TCO_MODE_NORMAL1    2'h1
`define TCO_MODE_COMP_PWM   2'h2
`define TCO_MODE_RSYNC_PWM  2'h3

// pwm_output_level_control fields
`define TCO_LC_RESET        8'hFF
`define TCO_LC_FIXED        5'h1F
`define TCO_LC_BITS_RESET   2'h3
`define TCO_LC_UPPER_BIT    1
`define TCO_LC_LOWER_BIT    0

// channel_counter values
`define TCO_CNT_RESET       16'h0000
`define TCO_CNT_MAX         16'hFFFF

// prescaler sources 4..7 are external pin levels
`define TCO_SRC_PIN_FIRST   4

`endif

// file: hw/tco_counter.v
`include "tco_defs.vh"
`default_nettype none

module tco_counter #(
    parameter WIDTH = 16
) (
    input  wire             clk_i,
    input  wire             init_i,
    input  wire             ce_i,
    input  wire             step_i,
    input  wire             down_i,
    input  wire             clear_i,
    input  wire             wr_i,
    input  wire [1:0]       be_i,
    input  wire [WIDTH-1:0] wdata_i,
    output reg  [WIDTH-1:0] count_o,
    output reg              ovf_o,
    output reg              unf_o
);

    reg [WIDTH-1:0] count_nxt;
    reg             ovf_nxt;
    reg             unf_nxt;

    always @* begin
        count_nxt = count_o;
        ovf_nxt   = 1'b0;
        unf_nxt   = 1'b0;
        // a cpu write beats both clear and count in the same cycle
        if (wr_i) begin
            if (be_i[1])
                count_nxt[WIDTH-1:8] = wdata_i[WIDTH-1:8];
            if (be_i[0])
                count_nxt[7:0] = wdata_i[7:0];
        end else if (clear_i) begin
            count_nxt = `TCO_CNT_RESET;
        end else if (step_i) begin
            if (down_i) begin
                count_nxt = count_o - {{(WIDTH-1){1'b0}}, 1'b1};
                unf_nxt   = (count_o == `TCO_CNT_RESET);
            end else begin
                count_nxt = count_o + {{(WIDTH-1){1'b0}}, 1'b1};
                ovf_nxt   = (count_o == `TCO_CNT_MAX);
            end
        end
    end

    always @(posedge clk_i) begin
        if (init_i) begin
            count_o <= `TCO_CNT_RESET;
            ovf_o   <= 1'b0;
            unf_o   <= 1'b0;
        end else if (ce_i) begin
            count_o <= count_nxt;
            ovf_o   <= ovf_nxt;
            unf_o   <= unf_nxt;
        end
    end

endmodule

`default_nettype wire

// file: hw/tco_timer_combination.v
// Operation
// - function control resets to C0/40; bit 7 undefined, any value accepted
// - function control bit 6 always reads one; software writes one there
// - mode field 00/01 normal, 10 complementary pwm, 11 reset-synced pwm
// - combined pwm modes override the channel 3/4 pwm select bits
// - bits 3..0 enable buffer mode for 4B, 4A, 3B, 3A; reset zero
// - output level bits act only in complementary or reset-synchronized mode
// - upper level bit zero inverts ch3 A, ch4 A, ch4 B
// - lower level bit zero inverts ch3 B, ch4 XA, ch4 XB
// - output control resets FF/7F; bits 6..2 read one; bit 7 undefined
// - five 16-bit counters, each ticks on its prescaler-selected source; ch2 steps on phase_step_i in phase mode
// - ch0/1 up only; ch2 up/down in phase mode; ch3/4 in complementary
// - selected compare match or capture on A or B clears counter
// - wrap from FFFF to 0000 sets that channel's overflow flag
// - decrement from 0000 to FFFF also sets the flag, except on ch2 with direction select 1
// - counters support 16-bit word and 8-bit byte reads and writes
// - reset and standby entry clear every counter to 0000
// - channel 2 direction select: 0 flags both wraps, 1 overflow only
`include "tco_defs.vh"
`default_nettype none

module tco_timer_combination #(
    parameter CHANNELS = 5,
    parameter CW       = 16
) (
    input  wire                  clk_i,
    input  wire                  rst_i,
    input  wire                  ce_i,
    input  wire                  standby_i,
    // cpu register port
    input  wire [2:0]            bus_addr_i,
    input  wire                  bus_wr_i,
    input  wire                  bus_rd_i,
    input  wire [1:0]            bus_be_i,
    input  wire [15:0]           bus_wdata_i,
    output reg  [15:0]           bus_rdata_o,
    // count sources: 3..0 internal strobes, 7..4 external pin levels
    input  wire [7:0]            clk_src_i,
    input  wire [3*CHANNELS-1:0] prescaler_select_i,
    // channel 2 phase counting
    input  wire                  phase_mode_i,
    input  wire                  phase_step_i,
    input  wire                  phase_down_i,
    input  wire                  overflow_direction_sel_i,
    // channel 3/4 complementary direction, bit 0 ch3, bit 1 ch4
    input  wire [1:0]            comp_down_i,
    // counter clear: event and clear selection, per channel
    input  wire [CHANNELS-1:0]   match_a_i,
    input  wire [CHANNELS-1:0]   match_b_i,
    input  wire [CHANNELS-1:0]   clear_on_a_i,
    input  wire [CHANNELS-1:0]   clear_on_b_i,
    output wire [CHANNELS-1:0]   overflow_flag_set_o,
    // per-channel pwm selects of channels 3 and 4
    input  wire                  pwm_sel_ch3_i,
    input  wire                  pwm_sel_ch4_i,
    output wire                  pwm_eff_ch3_o,
    output wire                  pwm_eff_ch4_o,
    output wire                  comp_pwm_o,
    output wire                  rsync_pwm_o,
    output wire                  buffer_en_ch3_a_o,
    output wire                  buffer_en_ch3_b_o,
    output wire                  buffer_en_ch4_a_o,
    output wire                  buffer_en_ch4_b_o,
    // raw waveform levels from the compare logic
    input  wire                  ch3_raw_a_i,
    input  wire                  ch3_raw_b_i,
    input  wire                  ch4_raw_a_i,
    input  wire                  ch4_raw_b_i,
    input  wire                  ch4_raw_xa_i,
    input  wire                  ch4_raw_xb_i,
    output reg                   ch3_output_a_o,
    output reg                   ch3_output_b_o,
    output reg                   ch4_output_a_o,
    output reg                   ch4_output_b_o,
    output reg                   ch4_comp_output_a_o,
    output reg                   ch4_comp_output_b_o,
    output wire [CW*CHANNELS-1:0] channel_counter_o
);

    localparam NPIN = 8 - `TCO_SRC_PIN_FIRST;

    // standby entry initializes exactly like reset
    wire init = rst_i | standby_i;

    function is_combined;
        input [1:0] mode;
        begin
            is_combined = (mode == `TCO_MODE_COMP_PWM) ||
                          (mode == `TCO_MODE_RSYNC_PWM);
        end
    endfunction

    reg  [7:0] func_ctrl_r;
    reg  [1:0] level_ctrl_r;
    reg        level_b7_r;

    wire [1:0] comb_mode = func_ctrl_r[`TCO_FC_MODE_HI:`TCO_FC_MODE_LO];
    wire       combined  = is_combined(comb_mode);
    wire       comp_mode = (comb_mode == `TCO_MODE_COMP_PWM);

    // ---- external pin sources: two-stage sync, then rising edge ----
    reg  [NPIN-1:0] pin_meta_r;
    reg  [NPIN-1:0] pin_sync_r;
    reg  [NPIN-1:0] pin_last_r;
    wire [7:0]      src_tick;

    always @(posedge clk_i) begin
        if (init) begin
            pin_meta_r <= {NPIN{1'b0}};
            pin_sync_r <= {NPIN{1'b0}};
            pin_last_r <= {NPIN{1'b0}};
        end else if (ce_i) begin
            pin_meta_r <= clk_src_i[7:`TCO_SRC_PIN_FIRST];
            pin_sync_r <= pin_meta_r;
            pin_last_r <= pin_sync_r;
        end
    end

    assign src_tick[`TCO_SRC_PIN_FIRST-1:0] =
        clk_src_i[`TCO_SRC_PIN_FIRST-1:0];
    assign src_tick[7:`TCO_SRC_PIN_FIRST] = pin_sync_r & ~pin_last_r;

    // ---- register write decode ----
    wire wr_func  = bus_wr_i & (bus_addr_i == `TCO_IDX_FUNC_CTRL);
    wire wr_level = bus_wr_i & (bus_addr_i == `TCO_IDX_LEVEL_CTRL);

    always @(posedge clk_i) begin
        if (init) begin
            func_ctrl_r  <= `TCO_FC_RESET;
            level_ctrl_r <= `TCO_LC_BITS_RESET;
            level_b7_r   <= 1'b1;
        end else if (ce_i) begin
            if (wr_func && bus_be_i[0]) begin
                func_ctrl_r[7] <= bus_wdata_i[7];
                // bit 6 is held at one whatever is written
                func_ctrl_r[`TCO_FC_FIXED_BIT] <= 1'b1;
                func_ctrl_r[5:0] <= bus_wdata_i[5:0];
            end
            if (wr_level && bus_be_i[0]) begin
                level_b7_r   <= bus_wdata_i[7];
                level_ctrl_r <= bus_wdata_i[1:0];
            end
        end
    end

    // ---- mode outputs ----
    assign comp_pwm_o  = comp_mode;
    assign rsync_pwm_o = (comb_mode == `TCO_MODE_RSYNC_PWM);
    assign pwm_eff_ch3_o = pwm_sel_ch3_i & ~combined;
    assign pwm_eff_ch4_o = pwm_sel_ch4_i & ~combined;
    assign buffer_en_ch3_a_o = func_ctrl_r[0];
    assign buffer_en_ch3_b_o = func_ctrl_r[1];
    assign buffer_en_ch4_a_o = func_ctrl_r[2];
    assign buffer_en_ch4_b_o = func_ctrl_r[3];

    // ---- output level control ----
    // outside the combined modes the level bits have no effect at all
    wire inv_upper = combined & ~level_ctrl_r[`TCO_LC_UPPER_BIT];
    wire inv_lower = combined & ~level_ctrl_r[`TCO_LC_LOWER_BIT];

    always @(posedge clk_i) begin
        if (init) begin
            ch3_output_a_o      <= 1'b0;
            ch3_output_b_o      <= 1'b0;
            ch4_output_a_o      <= 1'b0;
            ch4_output_b_o      <= 1'b0;
            ch4_comp_output_a_o <= 1'b0;
            ch4_comp_output_b_o <= 1'b0;
        end else if (ce_i) begin
            ch3_output_a_o      <= ch3_raw_a_i ^ inv_upper;
            ch4_output_a_o      <= ch4_raw_a_i ^ inv_upper;
            ch4_output_b_o      <= ch4_raw_b_i ^ inv_upper;
            ch3_output_b_o      <= ch3_raw_b_i ^ inv_lower;
            ch4_comp_output_a_o <= ch4_raw_xa_i ^ inv_lower;
            ch4_comp_output_b_o <= ch4_raw_xb_i ^ inv_lower;
        end
    end

    // ---- channel counters ----
    wire [CHANNELS-1:0] ovf;
    wire [CHANNELS-1:0] unf;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : g_chan
            wire [2:0] sel  = prescaler_select_i[3*g+2:3*g];
            wire       tick = src_tick[sel];
            wire       step;
            wire       down;
            // compared at 32 bits: a genvar takes no part-select
            wire       wr   = bus_wr_i &
                              ({29'h0, bus_addr_i} == `TCO_IDX_CNT0 + g);
            wire       clr  = (match_a_i[g] & clear_on_a_i[g]) |
                              (match_b_i[g] & clear_on_b_i[g]);

            if (g == 2) begin : g_phase
                // phase counting replaces the prescaler source
                assign step = phase_mode_i ? phase_step_i : tick;
                assign down = phase_mode_i & phase_down_i;
                assign overflow_flag_set_o[g] = ovf[g] |
                    (unf[g] & ~overflow_direction_sel_i);
            end else if (g >= 3) begin : g_comp
                assign step = tick;
                assign down = comp_mode & comp_down_i[g-3];
                assign overflow_flag_set_o[g] = ovf[g] | unf[g];
            end else begin : g_up
                assign step = tick;
                assign down = 1'b0;
                assign overflow_flag_set_o[g] = ovf[g];
            end

            tco_counter #(
                .WIDTH (CW)
            ) u_cnt (
                .clk_i   (clk_i),
                .init_i  (init),
                .ce_i    (ce_i),
                .step_i  (step),
                .down_i  (down),
                .clear_i (clr),
                .wr_i    (wr),
                .be_i    (bus_be_i),
                .wdata_i (bus_wdata_i[CW-1:0]),
                .count_o (channel_counter_o[CW*g+CW-1:CW*g]),
                .ovf_o   (ovf[g]),
                .unf_o   (unf[g])
            );
        end
    endgenerate

    // ---- read path, registered one cycle after the strobe ----
    reg  [15:0] rd_mux;
    integer     i;

    always @* begin
        rd_mux = 16'h0000;
        if (bus_addr_i == `TCO_IDX_FUNC_CTRL)
            rd_mux[7:0] = func_ctrl_r;
        else if (bus_addr_i == `TCO_IDX_LEVEL_CTRL)
            rd_mux[7:0] = {level_b7_r, `TCO_LC_FIXED, level_ctrl_r};
        else begin
            for (i = 0; i < CHANNELS; i = i + 1) begin
                if (bus_addr_i == (`TCO_IDX_CNT0 + i[2:0]))
                    rd_mux = channel_counter_o[CW*i +: CW];
            end
        end
        if (!bus_be_i[1])
            rd_mux[15:8] = 8'h00;
        if (!bus_be_i[0])
            rd_mux[7:0] = 8'h00;
    end

    always @(posedge clk_i) begin
        if (init)
            bus_rdata_o <= 16'h0000;
        else if (ce_i && bus_rd_i)
            bus_rdata_o <= rd_mux;
    end

endmodule

`default_nettype wire

// file: sim/tco_checker.sv
`default_nettype none
module tco_checker #(
    parameter CHANNELS = 5,
    parameter CW       = 16
) (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic                   ce_i,
    input wire logic                   standby_i,
    input wire logic [2:0]             bus_addr_i,
    input wire logic                   bus_wr_i,
    input wire logic                   bus_rd_i,
    input wire logic [1:0]             bus_be_i,
    input wire logic [15:0]            bus_rdata_o,
    input wire logic [CHANNELS-1:0]    match_a_i,
    input wire logic [CHANNELS-1:0]    match_b_i,
    input wire logic [CHANNELS-1:0]    clear_on_a_i,
    input wire logic [CHANNELS-1:0]    overflow_flag_set_o,
    input wire logic                   pwm_sel_ch3_i,
    input wire logic                   pwm_eff_ch3_o,
    input wire logic                   comp_pwm_o,
    input wire logic                   rsync_pwm_o,
    input wire logic                   ch3_raw_a_i,
    input wire logic                   ch3_output_a_o,
    input wire logic [CW*CHANNELS-1:0] channel_counter_o
);
    default clocking @(posedge clk_i); endclocking
    // standby reinitialises like reset, so both silence the checks except AST_STBY, which only reset disables
    default disable iff (rst_i || standby_i);
    logic [15:0] c0;
    assign c0 = channel_counter_o[15:0];
    AST_MODE_EXCL: assert property (
        ce_i && bus_rd_i && !bus_wr_i && bus_addr_i == 3'h0 && bus_be_i[0]
        |=> !(comp_pwm_o && rsync_pwm_o) &&
            bus_rdata_o[5] == $past(comp_pwm_o || rsync_pwm_o))
        else $error("combined mode outputs disagree with mode field");
    AST_PWM_OVR: assert property (
        pwm_eff_ch3_o == (pwm_sel_ch3_i && !comp_pwm_o && !rsync_pwm_o))
        else $error("channel pwm select not overridden");
    AST_OUT_DIRECT: assert property (
        ce_i && !comp_pwm_o && !rsync_pwm_o
        |=> ch3_output_a_o == $past(ch3_raw_a_i))
        else $error("output level altered outside combined mode");
    AST_CNT_STEP: assert property (
        ce_i && !bus_wr_i && !match_a_i[0] && !match_b_i[0]
        |=> c0 == $past(c0) || c0 == $past(c0) + 16'h0001)
        else $error("channel 0 moved other than one up");
    AST_CLEAR_A: assert property (
        ce_i && !bus_wr_i && match_a_i[1] && clear_on_a_i[1]
        |=> channel_counter_o[2*CW-1:CW] == 16'h0000)
        else $error("channel 1 not cleared on match");
    AST_OVF0: assert property (
        overflow_flag_set_o[0] |-> $past(c0) == 16'hFFFF && c0 == 16'h0000)
        else $error("overflow pulse without wrap");
    AST_STBY: assert property (disable iff (rst_i)
        standby_i |=> channel_counter_o == '0)
        else $error("standby did not clear counters");
    AST_FC_BIT6: assert property (
        ce_i && bus_rd_i && bus_addr_i == 3'h0 && bus_be_i[0]
        |=> bus_rdata_o[6])
        else $error("function control bit 6 read zero");
    AST_LC_FIXED: assert property (
        ce_i && bus_rd_i && bus_addr_i == 3'h1 && bus_be_i[0]
        |=> bus_rdata_o[6:2] == 5'h1F)
        else $error("level control fixed bits not one");
endmodule
bind tco_timer_combination tco_checker #(.CHANNELS(CHANNELS), .CW(CW)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .standby_i(standby_i),
    .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_be_i(bus_be_i), .bus_rdata_o(bus_rdata_o), .match_a_i(match_a_i),
    .match_b_i(match_b_i), .clear_on_a_i(clear_on_a_i),
    .overflow_flag_set_o(overflow_flag_set_o), .pwm_sel_ch3_i(pwm_sel_ch3_i),
    .pwm_eff_ch3_o(pwm_eff_ch3_o), .comp_pwm_o(comp_pwm_o),
    .rsync_pwm_o(rsync_pwm_o), .ch3_raw_a_i(ch3_raw_a_i),
    .ch3_output_a_o(ch3_output_a_o), .channel_counter_o(channel_counter_o));
`default_nettype wire

// file: sim/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i;
    logic        rst_i = 1'b1;
    logic        sb = 1'b0, wr = 1'b0, rd = 1'b0, pm = 1'b0, pd = 1'b0;
    logic        fd = 1'b0, p3 = 1'b0, p4 = 1'b0, ce = 1'b1;
    logic [2:0]  addr = 3'h0;
    logic [1:0]  be = 2'h0, cd = 2'h0;
    logic [15:0] wd = 16'h0000;
    logic [8:0]  tick = 9'h000;
    logic [14:0] sel = 15'h0000;
    logic [4:0]  ma = 5'h00, mb = 5'h00, ca = 5'h00, cb = 5'h00;
    logic [5:0]  raw = 6'h00;
    logic [4:0]  f;
    logic [2:0]  m, l;
    wire  [15:0] rdata;
    wire  [4:0]  ovf;
    wire  [3:0]  bufo;
    wire  [5:0]  outs;
    wire  [79:0] cnt_o;
    wire         e3, e4, cp, rp;
    int          mismatches = 0;
    int          n_tests = 0;

    tco_timer_combination u_tco_timer_combination (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .standby_i(sb),
        .bus_addr_i(addr), .bus_wr_i(wr), .bus_rd_i(rd), .bus_be_i(be),
        .bus_wdata_i(wd), .bus_rdata_o(rdata), .clk_src_i(tick[7:0]),
        .prescaler_select_i(sel), .phase_mode_i(pm), .phase_step_i(tick[8]),
        .phase_down_i(pd), .overflow_direction_sel_i(fd), .comp_down_i(cd),
        .match_a_i(ma), .match_b_i(mb), .clear_on_a_i(ca),
        .clear_on_b_i(cb), .overflow_flag_set_o(ovf), .pwm_sel_ch3_i(p3),
        .pwm_sel_ch4_i(p4), .pwm_eff_ch3_o(e3), .pwm_eff_ch4_o(e4),
        .comp_pwm_o(cp), .rsync_pwm_o(rp), .buffer_en_ch3_a_o(bufo[0]),
        .buffer_en_ch3_b_o(bufo[1]), .buffer_en_ch4_a_o(bufo[2]),
        .buffer_en_ch4_b_o(bufo[3]), .ch3_raw_a_i(raw[5]),
        .ch4_raw_a_i(raw[4]), .ch4_raw_b_i(raw[3]), .ch3_raw_b_i(raw[2]),
        .ch4_raw_xa_i(raw[1]), .ch4_raw_xb_i(raw[0]),
        .ch3_output_a_o(outs[5]), .ch4_output_a_o(outs[4]),
        .ch4_output_b_o(outs[3]), .ch3_output_b_o(outs[2]),
        .ch4_comp_output_a_o(outs[1]), .ch4_comp_output_b_o(outs[0]),
        .channel_counter_o(cnt_o));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic cyc;
        @(negedge clk_i);
    endtask

    // an idle cycle after each access keeps strobes from retriggering
    task automatic bus(input logic w, input logic [2:0] a,
                       input logic [1:0] b, input logic [15:0] d);
        wr = w;
        rd = ~w;
        addr = a;
        be = b;
        wd = d;
        cyc;
        wr = 1'b0;
        rd = 1'b0;
        cyc;
    endtask

    task automatic step(input int s, output logic [4:0] fl);
        tick[s] = 1'b1;
        cyc;
        tick[s] = 1'b0;
        fl = ovf;
        cyc;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] cnt(input int g);
        return cnt_o[16*g +: 16];
    endfunction

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic t_reset;
        bus(1'b0, 3'h0, 2'h3, 16'h0000);
        chk(rdata, 16'h00C0);
        bus(1'b0, 3'h1, 2'h3, 16'h0000);
        chk(rdata, 16'h00FF);
        for (int g = 0; g < 5; g++) chk(cnt(g), 16'h0000);
        chk(16'(bufo), 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_regs;
        bus(1'b1, 3'h0, 2'h1, 16'h000F);
        bus(1'b0, 3'h0, 2'h1, 16'h0000);
        chk(rdata, 16'h004F);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 3'h0, 2'h1, 16'(8'h40 | (8'h01 << i)));
            chk(16'(bufo), 16'(4'h1 << i));
        end
        bus(1'b1, 3'h1, 2'h1, 16'h0000);
        bus(1'b0, 3'h1, 2'h1, 16'h0000);
        chk(rdata, 16'h007C);
        bus(1'b1, 3'h7, 2'h3, 16'hFFFF);
        bus(1'b0, 3'h7, 2'h3, 16'h0000);
        chk(rdata, 16'h0000);
        $display("test registers done");
    endtask

    task automatic t_modes;
        p3 = 1'b1;
        p4 = 1'b1;
        for (m = 3'h0; m < 3'h4; m++) begin
            for (l = 3'h0; l < 3'h4; l++) begin
                raw = {m[1:0], l[1:0], ~m[1:0]};
                bus(1'b1, 3'h1, 2'h1, {8'h00, 6'h3F, l[1:0]});
                bus(1'b1, 3'h0, 2'h1, {8'h00, 2'h3, m[1:0], 4'h0});
                bus(1'b0, 3'h0, 2'h1, 16'h0000);
                chk(rdata, {8'h00, 2'h3, m[1:0], 4'h0});
                chk(16'(cp), 16'(m == 3'h2));
                chk(16'(rp), 16'(m == 3'h3));
                chk(16'({e4, e3}), 16'({2{m < 3'h2}}));
                chk(16'(outs), 16'(raw ^ {{3{m[1] & ~l[1]}},
                                          {3{m[1] & ~l[0]}}}));
            end
        end
        bus(1'b1, 3'h0, 2'h1, 16'h00C0);
        $display("test modes done");
    endtask

    task automatic t_count;
        sel = 15'h0008;
        bus(1'b1, 3'h2, 2'h3, 16'hFFFE);
        step(0, f);
        chk(cnt(0), 16'hFFFF);
        chk(16'(f), 16'h0000);
        step(0, f);
        chk(cnt(0), 16'h0000);
        chk(16'(f), 16'h0001);
        chk(cnt(1), 16'h0000);
        bus(1'b1, 3'h2, 2'h3, 16'h1234);
        bus(1'b1, 3'h2, 2'h2, 16'hAB00);
        bus(1'b0, 3'h2, 2'h3, 16'h0000);
        chk(rdata, 16'hAB34);
        bus(1'b0, 3'h2, 2'h1, 16'h0000);
        chk(rdata, 16'h0034);
        bus(1'b1, 3'h3, 2'h3, 16'h0005);
        ma[1] = 1'b1;
        ca[1] = 1'b1;
        step(1, f);
        chk(cnt(1), 16'h0000);
        ma[1] = 1'b0;
        mb[1] = 1'b1;
        step(1, f);
        chk(cnt(1), 16'h0001);
        cb[1] = 1'b1;
        step(1, f);
        chk(cnt(1), 16'h0000);
        mb[1] = 1'b0;
        $display("test counters done");
    endtask

    task automatic t_down;
        sel = 15'h0000;
        pm = 1'b1;
        pd = 1'b1;
        bus(1'b1, 3'h4, 2'h3, 16'h0000);
        step(8, f);
        chk(cnt(2), 16'hFFFF);
        chk(16'(f[2]), 16'h0001);
        fd = 1'b1;
        bus(1'b1, 3'h4, 2'h3, 16'h0000);
        step(8, f);
        chk(16'(f[2]), 16'h0000);
        pd = 1'b0;
        step(8, f);
        chk(cnt(2), 16'h0000);
        chk(16'(f[2]), 16'h0001);
        pm = 1'b0;
        bus(1'b1, 3'h0, 2'h1, 16'h00E0);
        bus(1'b1, 3'h5, 2'h3, 16'h0000);
        cd = 2'h1;
        step(0, f);
        chk(cnt(3), 16'hFFFF);
        chk(16'(f[3]), 16'h0001);
        cd = 2'h0;
        $display("test down counting done");
    endtask

    // a held pin level counts once; a low enable freezes count and writes
    task automatic t_edge;
        sel = 15'h0020;
        bus(1'b1, 3'h3, 2'h3, 16'h0000);
        tick[4] = 1'b1;
        repeat (5) cyc;
        chk(cnt(1), 16'h0001);
        tick[4] = 1'b0;
        repeat (4) cyc;
        chk(cnt(1), 16'h0001);
        sel = 15'h0000;
        bus(1'b1, 3'h2, 2'h3, 16'h0010);
        ce = 1'b0;
        step(0, f);
        bus(1'b1, 3'h2, 2'h3, 16'h0099);
        chk(cnt(0), 16'h0010);
        ce = 1'b1;
        step(0, f);
        chk(cnt(0), 16'h0011);
        $display("test pin edge and freeze done");
    endtask

    task automatic t_standby;
        sb = 1'b1;
        cyc;
        sb = 1'b0;
        cyc;
        for (int g = 0; g < 5; g++) chk(cnt(g), 16'h0000);
        bus(1'b0, 3'h0, 2'h3, 16'h0000);
        chk(rdata, 16'h00C0);
        $display("test standby done");
    endtask

    initial begin
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        t_reset;
        t_regs;
        t_modes;
        t_count;
        t_down;
        t_edge;
        t_standby;
        end_of_test;
    end

    // the whole sequence needs well under 400 cycles
    initial begin
        repeat (3000) @(posedge clk_i);
        mismatches++;
        end_of_test;
    end
endmodule
`default_nettype wire
